// ### swd_pkg.sv
// Package and tick divider for the supervisor watchdog
package swd_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_LOAD  = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_VALUE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CTL   = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_ICR   = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_RIS   = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_MIS   = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_TEST  = 12'h418;
  localparam logic [ADDR_W-1:0] OFS_LOCK  = 12'hC00;

  localparam int CTL_TIMEOUT_IRQ_ENABLE_BIT  = 0;
  localparam int CTL_RESET_OUTPUT_ENABLE_BIT  = 1;
  localparam int TEST_STALL_BIT = 8;

  localparam logic [DATA_W-1:0] LOAD_RESET = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNLOCK_KEY = 32'h1ACC_E551;

  localparam int CLK_HZ  = 50_000_000;
  localparam int WDOG_HZ = 50_000_000;
  localparam int TICK_DIV = CLK_HZ / WDOG_HZ;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } swd_bus_req_t;

endpackage

`timescale 1ns/1ns

module swd_tick_gen #(
  parameter int DIV = 1
) (
  input  wire logic clk,      // System clock
  input  wire logic rst_n,    // Synchronised reset, active low
  input  wire logic enable,   // Watchdog clock gate
  output logic      tick      // One-cycle count enable
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;

  // A gated clock freezes the divider phase instead of resetting it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (enable) begin
      cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end
  end

  assign tick = enable && (cnt == LAST);

endmodule

// ### swd_core.sv
// Supervisor watchdog: down counter, time-out interrupt, reset request, lock
//
// Behaviour
// - 32-bit down counter starts from a software-written load value.
// - Counting advances only while the watchdog clock enable is high.
// - With stall enabled, debug halt pauses counting; it resumes afterwards.
// - Once enabled, counter reaching zero gives the first time-out.
// - Setting the interrupt enable also starts the counter.
// - After a time-out the counter reloads and keeps counting down.
// - Second time-out with interrupt pending and reset enabled asserts reset.
// - Clearing the interrupt before second time-out reloads; no reset follows.
// - Writing the load value while running reloads the counter at once.
// - Writing the load value leaves a pending interrupt untouched.
// - Enabling the interrupt preloads the counter from the load value.
// - Locked registers refuse configuration writes.
// - Interrupt output is masked; raw status stays readable regardless.
// - Reset generation has its own enable; disabled means no reset.
// - Any write to lock register locks; the unlock key unlocks.
// - Once interrupt enable is set, control writes are ignored until reset.
// - Loading zero raises the time-out interrupt immediately.
// - Any write to clear register reloads counter and clears interrupt, unless a time-out lands in the same cycle.
`timescale 1ns/1ns

module swd_core
  import swd_pkg::*;
#(
  parameter int TICK_DIVIDE = TICK_DIV
) (
  input  wire logic          clk,          // System clock, 50 MHz
  input  wire logic          rstn,         // Asynchronous reset, active low
  input  wire swd_bus_req_t  bus_req,      // Register access request
  output logic [DATA_W-1:0]  bus_rdata,    // Read data, cycle after read
  input  wire logic          wdog_clk_en,  // Watchdog clock enable
  input  wire logic          debug_halt,   // Processor halted in debug
  output logic               timeout_irq,  // Masked time-out interrupt
  output logic               sys_reset_req // System reset request
);

  logic rst_meta;
  logic rst_n;

  // Release is synchronised so every flop leaves reset on the same edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  logic [DATA_W-1:0] reload_value_reg;
  logic [DATA_W-1:0] count;
  logic              timeout_irq_enable;
  logic              reset_output_enable;
  logic              stall_enable;
  logic              locked;
  logic              raw_status;
  logic              wdog_tick;

  swd_tick_gen #(
    .DIV (TICK_DIVIDE)
  ) u_tick (
    .clk    (clk),
    .rst_n  (rst_n),
    .enable (wdog_clk_en),
    .tick   (wdog_tick)
  );

  // Bus strobe, address and data are registered every cycle, so each write acts one cycle after the request
  logic              wr_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q    <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
    end else begin
      wr_q    <= bus_req.wr;
      waddr_q <= bus_req.addr;
      wdata_q <= bus_req.wdata;
    end
  end

  logic wr_load;
  logic wr_ctl;
  logic wr_icr;
  logic wr_test;
  logic wr_lock;
  logic ctl_accept;
  logic irq_enable_rise;

  always_comb begin
    wr_load = wr_q && (waddr_q == OFS_LOAD) && !locked;
    wr_ctl  = wr_q && (waddr_q == OFS_CTL) && !locked;
    wr_icr  = wr_q && (waddr_q == OFS_ICR) && !locked;
    wr_test = wr_q && (waddr_q == OFS_TEST) && !locked;
    wr_lock = wr_q && (waddr_q == OFS_LOCK);
  end

  // Control freezes for good once the interrupt enable is set
  assign ctl_accept      = wr_ctl && !timeout_irq_enable;
  assign irq_enable_rise = ctl_accept && wdata_q[CTL_TIMEOUT_IRQ_ENABLE_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      locked <= 1'b0;
    end else if (wr_lock) begin
      locked <= (wdata_q != UNLOCK_KEY);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_irq_enable  <= 1'b0;
      reset_output_enable <= 1'b0;
    end else if (ctl_accept) begin
      timeout_irq_enable  <= wdata_q[CTL_TIMEOUT_IRQ_ENABLE_BIT];
      reset_output_enable <= wdata_q[CTL_RESET_OUTPUT_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_enable <= 1'b0;
    end else if (wr_test) begin
      stall_enable <= wdata_q[TEST_STALL_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_value_reg <= LOAD_RESET;
    end else if (wr_load) begin
      reload_value_reg <= wdata_q;
    end
  end

  logic count_step;
  logic timeout_event;
  logic [DATA_W-1:0] next_count;

  // The counter runs only after the enable; debug halt can freeze it
  assign count_step = timeout_irq_enable && wdog_tick
                      && !(stall_enable && debug_halt);
  assign timeout_event = count_step && (count == ZERO_WORD);

  always_comb begin
    next_count = count;
    if (wr_load) begin
      next_count = wdata_q;
    end else if (wr_icr || irq_enable_rise) begin
      next_count = reload_value_reg;
    end else if (timeout_event) begin
      next_count = reload_value_reg;
    end else if (count_step) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= LOAD_RESET;
    end else begin
      count <= next_count;
    end
  end

  // A time-out in the same cycle as a clear keeps the flag: the event wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_status <= 1'b0;
    end else if (timeout_event || (wr_load && wdata_q == ZERO_WORD)) begin
      raw_status <= 1'b1;
    end else if (wr_icr) begin
      raw_status <= 1'b0;
    end
  end

  // Pending flag is sampled before any clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_req <= 1'b0;
    end else if (timeout_event && raw_status && reset_output_enable) begin
      sys_reset_req <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_irq <= 1'b0;
    end else begin
      timeout_irq <= raw_status && timeout_irq_enable;
    end
  end

  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = ZERO_WORD;
    unique case (bus_req.addr)
      OFS_LOAD:  next_rdata = reload_value_reg;
      OFS_VALUE: next_rdata = count;
      OFS_CTL: begin
        next_rdata[CTL_TIMEOUT_IRQ_ENABLE_BIT] = timeout_irq_enable;
        next_rdata[CTL_RESET_OUTPUT_ENABLE_BIT] = reset_output_enable;
      end
      OFS_RIS:   next_rdata[0] = raw_status;
      OFS_MIS:   next_rdata[0] = raw_status && timeout_irq_enable;
      OFS_TEST:  next_rdata[TEST_STALL_BIT] = stall_enable;
      OFS_LOCK:  next_rdata[0] = locked;
      default:   next_rdata = ZERO_WORD;
    endcase
  end

  // Unmapped and write-only addresses read as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= ZERO_WORD;
    end else if (bus_req.rd) begin
      bus_rdata <= next_rdata;
    end else begin
      bus_rdata <= ZERO_WORD;
    end
  end

endmodule

// ### swd_core_assertions.sv
// Port checks of the supervisor watchdog
`timescale 1ns/1ns
module swd_core_assertions
  import swd_pkg::*;
(
  input wire logic              clk,          // Clock
  input wire logic              rstn,         // Reset, active low
  input wire swd_bus_req_t      bus_req,      // Bus request
  input wire logic [DATA_W-1:0] bus_rdata,    // Read data
  input wire logic              wdog_clk_en,  // Count enable
  input wire logic              debug_halt,   // Debug halt
  input wire logic              timeout_irq,  // Interrupt
  input wire logic              sys_reset_req // Reset request
);
  logic [3:0] icr_age;
  logic       timeout_irq_enable_seen;
  logic       reset_output_enable_seen;
  wire        wr_ctl = bus_req.wr && bus_req.addr == OFS_CTL;
  // Saturates so a long-pending interrupt never looks freshly cleared
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      icr_age <= 4'hF;
    else if (bus_req.wr && bus_req.addr == OFS_ICR)
      icr_age <= 4'h0;
    else if (icr_age != 4'hF)
      icr_age <= icr_age + 4'h1;
  end
  // Upper bounds only: a locked write still sets them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timeout_irq_enable_seen <= 1'b0;
      reset_output_enable_seen <= 1'b0;
    end else if (wr_ctl && !timeout_irq_enable_seen) begin
      timeout_irq_enable_seen <= bus_req.wdata[CTL_TIMEOUT_IRQ_ENABLE_BIT];
      reset_output_enable_seen <= bus_req.wdata[CTL_RESET_OUTPUT_ENABLE_BIT];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == ZERO_WORD)
    else $error("read data outside answer cycle");
  a_reset_sticky: assert property (sys_reset_req |=> sys_reset_req)
    else $error("reset request dropped");
  a_reset_after_irq: assert property ($rose(sys_reset_req) |-> timeout_irq)
    else $error("reset without pending interrupt");
  a_irq_clear_only: assert property ($fell(timeout_irq) |-> icr_age <= 4'h5)
    else $error("interrupt fell without clear");
  a_irq_needs_en: assert property ($rose(timeout_irq) |-> timeout_irq_enable_seen)
    else $error("interrupt while disabled");
  a_reset_needs_en: assert property ($rose(sys_reset_req) |-> reset_output_enable_seen)
    else $error("reset while reset disabled");
  a_release_quiet: assert property ($rose(rstn) |-> !timeout_irq && !sys_reset_req)
    else $error("outputs active at release");
  a_ctl_reserved: assert property ($past(bus_req.rd && bus_req.addr == OFS_CTL)
    |-> bus_rdata[31:2] == 30'h0000_0000)
    else $error("control reserved bits set");
endmodule

// ### swd_partner.sv
// Reset catcher beside the watchdog, gated by the time-out interrupt
`timescale 1ns/1ns
module swd_partner (
  input  wire logic clk,      // Clock
  input  wire logic irq,      // Time-out interrupt
  input  wire logic rst_req,  // Reset request
  output logic      rst_seen  // Reset request caught
);
  // Latches for good: real reset logic would restart the system here
  initial rst_seen = 1'b0;
  always @(posedge clk) begin
    if (rst_req && irq)
      rst_seen <= 1'b1;
  end
endmodule

// ### swd_core_tb.sv
// Testbench of the supervisor watchdog
`timescale 1ns/1ns
module swd_core_tb
  import swd_pkg::*;
;
  localparam logic [DATA_W-1:0] ONE = 32'h0000_0001;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  swd_bus_req_t      req = '0;
  logic [DATA_W-1:0] rdata;
  logic              en = 1'b1;
  logic              halt = 1'b0;
  logic              irq;
  logic              sreq;
  logic              rst_seen;
  logic [DATA_W-1:0] v;
  logic [DATA_W-1:0] w;
  int                n_fail = 0;
  int                n_checks = 0;
  int                cyc = 0;
  always #10 clk = ~clk;
  swd_core #(.TICK_DIVIDE(1)) swd_core_inst (.clk(clk), .rstn(rstn), .bus_req(req),
    .bus_rdata(rdata), .wdog_clk_en(en), .debug_halt(halt), .timeout_irq(irq),
    .sys_reset_req(sreq));
  swd_partner swd_partner_inst (.clk(clk), .irq(irq), .rst_req(sreq), .rst_seen(rst_seen));
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    do_reset();
    rc(OFS_LOAD, LOAD_RESET);
    rc(OFS_CTL, ZERO_WORD);
    wr(OFS_LOAD, ZERO_WORD);
    rc(OFS_RIS, ONE);
    chk(32'(irq), ZERO_WORD);
    wr(OFS_LOAD, 32'h0000_0050);
    rc(OFS_RIS, ONE);
    wr(OFS_TEST, 32'h0000_0100);
    wr(OFS_CTL, ONE);
    rd(OFS_VALUE, v);
    chk(32'(v <= 32'h0000_0050 && v > 32'h0000_0048), ONE);
    wr(OFS_LOAD, 32'h0000_0040);
    rd(OFS_VALUE, v);
    chk(32'(v <= 32'h0000_0040 && v > 32'h0000_0038), ONE);
    rc(OFS_RIS, ONE);
    rc(OFS_MIS, ONE);
    halt <= 1'b1;
    rd(OFS_VALUE, w);
    rc(OFS_VALUE, w);
    halt <= 1'b0;
    en <= 1'b0;
    rd(OFS_VALUE, w);
    rc(OFS_VALUE, w);
    en <= 1'b1;
    repeat (200) @(posedge clk);
    chk(32'(sreq), ZERO_WORD);
    wr(OFS_ICR, 32'h0000_1234);
    rc(OFS_RIS, ZERO_WORD);
    wr(OFS_LOCK, 32'h0000_0007);
    wr(OFS_LOAD, 32'h0000_0099);
    rc(OFS_LOAD, 32'h0000_0040);
    rc(OFS_LOCK, ONE);
    wr(OFS_LOCK, UNLOCK_KEY);
    rc(OFS_LOCK, ZERO_WORD);
    rc(12'h020, ZERO_WORD);
    do_reset();
    wr(OFS_LOAD, 32'h0000_0030);
    wr(OFS_CTL, 32'h0000_0003);
    wr(OFS_CTL, ZERO_WORD);
    rc(OFS_CTL, 32'h0000_0003);
    repeat (100) if (!irq) @(posedge clk);
    chk(32'(irq), ONE);
    wr(OFS_ICR, ZERO_WORD);
    rc(OFS_RIS, ZERO_WORD);
    repeat (30) @(posedge clk);
    chk(32'(sreq), ZERO_WORD);
    repeat (200) if (!sreq) @(posedge clk);
    // Partner catches the request one edge after it appears
    @(posedge clk);
    chk(32'(sreq & rst_seen), ONE);
    do_reset();
    chk(32'(sreq), ZERO_WORD);
    final_report();
  end
endmodule
bind swd_core swd_core_assertions swd_core_assertions_inst (.clk(clk), .rstn(rstn),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .wdog_clk_en(wdog_clk_en),
  .debug_halt(debug_halt), .timeout_irq(timeout_irq), .sys_reset_req(sys_reset_req));
